// file: pkg/ctrl_regs_pkg.sv
// constants and carrier types of the controller register bank
// assumes a single 100 MHz clock domain; register numbers are the
// serial-protocol register numbers, one 16-bit word each
package ctrl_regs_pkg;

  localparam int NUM_CFG = 23;

  // register numbers
  localparam logic [15:0] ADDR_CTRL_STATUS   = 16'h0fa3;
  localparam logic [15:0] ADDR_ALARM_STATE   = 16'h0fa4;
  localparam logic [15:0] ADDR_SPEED         = 16'h0ffc;
  localparam logic [15:0] ADDR_FRAMING       = 16'h0ffd;
  localparam logic [15:0] ADDR_RETX_SRC      = 16'h0fff;
  localparam logic [15:0] ADDR_RETX_LOW      = 16'h1000;
  localparam logic [15:0] ADDR_RETX_HIGH     = 16'h1001;
  localparam logic [15:0] ADDR_MENU_CODE     = 16'h1002;
  localparam logic [15:0] ADDR_TUNE_LOCK     = 16'h1003;
  localparam logic [15:0] ADDR_TUNE_LOW      = 16'h1004;
  localparam logic [15:0] ADDR_TUNE_HIGH     = 16'h1005;
  localparam logic [15:0] ADDR_MON_EXIT      = 16'h1006;
  localparam logic [15:0] ADDR_CD_ENABLE     = 16'h1007;
  localparam logic [15:0] ADDR_CD_DURATION   = 16'h1008;
  localparam logic [15:0] ADDR_AUX_MON       = 16'h1009;
  localparam logic [15:0] ADDR_HEAT_MON      = 16'h100a;
  localparam logic [15:0] ADDR_OUT3_PERIOD   = 16'h100f;
  localparam logic [15:0] ADDR_STEP_FB       = 16'h1011;
  localparam logic [15:0] ADDR_SHORT_SP      = 16'h1012;
  localparam logic [15:0] ADDR_SHORT_HY      = 16'h1013;
  localparam logic [15:0] ADDR_VALVE_OPEN    = 16'h1014;
  localparam logic [15:0] ADDR_VALVE_CLOSE   = 16'h1015;
  localparam logic [15:0] ADDR_VALVE_MINWORK = 16'h1016;
  localparam logic [15:0] ADDR_YSIG_MIN      = 16'h1017;
  localparam logic [15:0] ADDR_YSIG_MAX      = 16'h1018;

  // slot of each setting in the storage array
  localparam int IDX_SPEED = 0;
  localparam int IDX_FRAMING = 1;
  localparam int IDX_RETX_SRC = 2;
  localparam int IDX_RETX_LOW = 3;
  localparam int IDX_RETX_HIGH = 4;
  localparam int IDX_MENU_CODE = 5;
  localparam int IDX_TUNE_LOCK = 6;
  localparam int IDX_TUNE_LOW = 7;
  localparam int IDX_TUNE_HIGH = 8;
  localparam int IDX_MON_EXIT = 9;
  localparam int IDX_CD_ENABLE = 10;
  localparam int IDX_CD_DURATION = 11;
  localparam int IDX_AUX_MON = 12;
  localparam int IDX_HEAT_MON = 13;
  localparam int IDX_OUT3_PERIOD = 14;
  localparam int IDX_STEP_FB = 15;
  localparam int IDX_SHORT_SP = 16;
  localparam int IDX_SHORT_HY = 17;
  localparam int IDX_VALVE_OPEN = 18;
  localparam int IDX_VALVE_CLOSE = 19;
  localparam int IDX_VALVE_MINWORK = 20;
  localparam int IDX_YSIG_MIN = 21;
  localparam int IDX_YSIG_MAX = 22;

  localparam logic [0:NUM_CFG-1][15:0] CFG_ADDR = {
    ADDR_SPEED, ADDR_FRAMING, ADDR_RETX_SRC, ADDR_RETX_LOW,
    ADDR_RETX_HIGH, ADDR_MENU_CODE, ADDR_TUNE_LOCK, ADDR_TUNE_LOW,
    ADDR_TUNE_HIGH, ADDR_MON_EXIT, ADDR_CD_ENABLE, ADDR_CD_DURATION,
    ADDR_AUX_MON, ADDR_HEAT_MON, ADDR_OUT3_PERIOD, ADDR_STEP_FB,
    ADDR_SHORT_SP, ADDR_SHORT_HY, ADDR_VALVE_OPEN, ADDR_VALVE_CLOSE,
    ADDR_VALVE_MINWORK, ADDR_YSIG_MIN, ADDR_YSIG_MAX};

  // accepted write range per slot
  localparam logic [0:NUM_CFG-1][15:0] CFG_MIN = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001,
    16'h0000, 16'h0000, 16'h0005, 16'h0000, 16'h0000, 16'h0000,
    16'h001e, 16'h001e, 16'h0001, 16'h0000, 16'h0000};
  localparam logic [0:NUM_CFG-1][15:0] CFG_MAX = {
    16'h0004, 16'h0004, 16'h0005, 16'hffff, 16'hffff, 16'h270f,
    16'h0001, 16'hffff, 16'hffff, 16'h00fa, 16'h0001, 16'h270f,
    16'h0001, 16'h0001, 16'h03e7, 16'h0001, 16'h01f4, 16'h01f4,
    16'h1770, 16'h1770, 16'h03e7, 16'h03e8, 16'h03e8};
  localparam logic [0:NUM_CFG-1][15:0] CFG_RESET = {
    16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h03e8, 16'h0000,
    16'h0001, 16'h0000, 16'h03e8, 16'h0000, 16'h0000, 16'h0001,
    16'h0000, 16'h0000, 16'h0032, 16'h0000, 16'h0000, 16'h0000,
    16'h001e, 16'h001e, 16'h0001, 16'h0000, 16'h03e8};

  // bit rate per speed code
  localparam logic [0:4][15:0] SPEED_BPS = {
    16'h12c0, 16'h2580, 16'h4b00, 16'h9600, 16'he100};

  // framing codes
  localparam logic [2:0] FRAME_OFF = 3'h0;
  localparam logic [2:0] FRAME_8N2 = 3'h1;
  localparam logic [2:0] FRAME_8E1 = 3'h2;
  localparam logic [2:0] FRAME_8O1 = 3'h3;
  localparam logic [2:0] FRAME_8N1 = 3'h4;

  // status word field positions
  localparam int ST_DP_MAIN = 0;
  localparam int ST_DP_ADD = 2;
  localparam int ST_TUNE_FAIL = 4;
  localparam int ST_SOFT_START = 5;
  localparam int ST_TIMER_DONE = 6;
  localparam int ST_MANUAL = 7;
  localparam int ST_TUNE_ACTIVE = 8;
  localparam int ST_PID_SET = 9;
  localparam int ST_RANGE_MAIN = 13;
  localparam int ST_RANGE_ADD = 14;
  localparam int ST_CTRL_ERROR = 15;
  localparam int AL_ALARM1 = 0;
  localparam int AL_HEATER_BURN = 4;
  localparam int AL_SHORT_OUT1 = 5;

  // access answer codes
  localparam logic [1:0] ANS_OK = 2'h0;
  localparam logic [1:0] ANS_BAD_ADDR = 2'h1;
  localparam logic [1:0] ANS_BAD_VALUE = 2'h2;
  localparam logic [1:0] ANS_READ_ONLY = 2'h3;

  typedef enum logic [2:0] {
    SRC_MAIN, SRC_ADDITIONAL, SRC_MAIN_MINUS_ADD, SRC_ADD_MINUS_MAIN,
    SRC_SETPOINT, SRC_DEVIATION
  } retx_source_t;

  typedef struct packed {
    logic [1:0] dp_main;
    logic [1:0] dp_additional;
    logic       tune_failed;
    logic       soft_start_active;
    logic       timer_finished;
    logic       manual_mode;
    logic       tune_active;
    logic [1:0] pid_set;
    logic       main_out_of_range;
    logic       additional_out_of_range;
    logic       controller_error;
  } ctrl_state_t;

  typedef struct packed {
    logic [2:0] alarm_active;
    logic       heater_burnout;
    logic       out1_short;
  } alarm_state_t;

  typedef struct packed {
    logic [15:0]  bit_rate;
    logic         link_enable;
    logic         parity_enable;
    logic         parity_odd;
    logic         two_stop_bits;
    retx_source_t retx_source;
    logic [15:0]  retx_low;
    logic [15:0]  retx_high;
    logic [15:0]  menu_code;
    logic         tune_permit;
    logic [15:0]  tune_low;
    logic [15:0]  tune_high;
    logic [7:0]   monitor_exit_delay;
    logic         countdown_run;
    logic [15:0]  countdown_tenth_min;
    logic         aux_monitor_on;
    logic         heater_monitor_on;
    logic [9:0]   out3_period_tenth_s;
    logic         stepper_feedback;
    logic [9:0]   short_setpoint;
    logic [9:0]   short_hysteresis;
    logic [12:0]  valve_open_tenth_s;
    logic [12:0]  valve_close_tenth_s;
    logic [9:0]   valve_min_work_tenth_s;
    logic [9:0]   ysig_min;
    logic [9:0]   ysig_max;
  } settings_t;

endpackage : ctrl_regs_pkg

// file: logic/value_range_check.sv
// combinational bounds test of one register value
// assumes bounds are constant per instance
`timescale 1ns/10ps
`default_nettype none
module value_range_check #(
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'hffff
) (
  input  wire logic [15:0] value,
  output logic             in_range
);
  assign in_range = (value >= LO) && (value <= HI);
endmodule : value_range_check
`default_nettype wire

// file: logic/controller_config_status_regs.sv
// register bank of the process controller: settings and status words
// assumes the serial protocol engine presents one register access per
// strobe on mclk, and status inputs come from logic on the same clock
//
// Behaviour
// - speed codes 0-4 give 4800..57600 bps
// - framing 0 off, 1-4 8N2 8E1 8O1 8N1
// - retransmit source takes values 0 to 5
// - low and high limits span retransmission
// - menu access code holds 0 to 9999
// - tuning lock bit, low and high thresholds
// - timer enable gates countdown, tenths minute
// - monitoring exit delay ranges 0 to 250
// - aux input, heater current monitor enables
// - output 3 period tenths second, max 999
// - stepper bit selects feedback or none
// - short alarm set point, hysteresis 0-500
// - valve open, close times 30 to 6000
// - minimum valve work time, tenths second
// - control signal min, max 0 to 1000
// - status bits 0-3 give decimal points
// - bit 4 tuning failed, bit 8 tuning
// - bit 5 soft start, bit 6 timer done
// - bit 7 manual, bits 9-10 PID set
// - bits 13-15 range errors, controller error
// - alarm word bits 0-2 for alarms 1-3
// - alarm bit 4 burnout, bit 5 short
`timescale 1ns/10ps
`default_nettype none
module controller_config_status_regs (
  input  wire logic                       mclk,
  input  wire logic                       rstn,
  input  wire logic [15:0]                reg_addr,
  input  wire logic                       reg_rd,
  input  wire logic                       reg_wr,
  input  wire logic [15:0]                reg_wdata,
  output logic [15:0]                     reg_rdata,
  output logic                            reg_ack,
  output logic [1:0]                      reg_answer,
  input  wire ctrl_regs_pkg::ctrl_state_t  ctrl_state,
  input  wire ctrl_regs_pkg::alarm_state_t alarm_state,
  output ctrl_regs_pkg::settings_t        settings
);

  typedef logic [ctrl_regs_pkg::NUM_CFG-1:0][15:0] cfg_array_t;

  typedef struct packed {
    cfg_array_t                cfg;
    logic [15:0]               rdata;
    logic                      ack;
    logic [1:0]                answer;
    ctrl_regs_pkg::settings_t  settings;
  } state_t;

  state_t state;
  state_t next_state;

  // {hit, slot} for a register number
  function automatic logic [5:0] cfg_lookup(input logic [15:0] a);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < ctrl_regs_pkg::NUM_CFG; i++) begin
      if (a == ctrl_regs_pkg::CFG_ADDR[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction : cfg_lookup

  // reserved bits stay zero since only named fields are placed
  function automatic logic [15:0] status_word(
    input ctrl_regs_pkg::ctrl_state_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[ctrl_regs_pkg::ST_DP_MAIN +: 2] = s.dp_main;
    w[ctrl_regs_pkg::ST_DP_ADD +: 2] = s.dp_additional;
    w[ctrl_regs_pkg::ST_TUNE_FAIL] = s.tune_failed;
    w[ctrl_regs_pkg::ST_TUNE_ACTIVE] = s.tune_active;
    w[ctrl_regs_pkg::ST_SOFT_START] = s.soft_start_active;
    w[ctrl_regs_pkg::ST_TIMER_DONE] = s.timer_finished;
    w[ctrl_regs_pkg::ST_MANUAL] = s.manual_mode;
    w[ctrl_regs_pkg::ST_PID_SET +: 2] = s.pid_set;
    w[ctrl_regs_pkg::ST_RANGE_MAIN] = s.main_out_of_range;
    w[ctrl_regs_pkg::ST_RANGE_ADD] =
      s.additional_out_of_range;
    w[ctrl_regs_pkg::ST_CTRL_ERROR] = s.controller_error;
    return w;
  endfunction : status_word

  function automatic logic [15:0] alarm_word(
    input ctrl_regs_pkg::alarm_state_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[ctrl_regs_pkg::AL_ALARM1 +: 3] = s.alarm_active;
    w[ctrl_regs_pkg::AL_HEATER_BURN] = s.heater_burnout;
    w[ctrl_regs_pkg::AL_SHORT_OUT1] = s.out1_short;
    return w;
  endfunction : alarm_word

  // per-slot bounds; an out-of-range write is refused and the old
  // value kept, so the control loop never sees an illegal setting
  logic [ctrl_regs_pkg::NUM_CFG-1:0] wdata_ok;

  generate
    for (genvar g = 0; g < ctrl_regs_pkg::NUM_CFG; g++) begin : g_bounds
      value_range_check #(
        .LO (ctrl_regs_pkg::CFG_MIN[g]),
        .HI (ctrl_regs_pkg::CFG_MAX[g])
      ) u_check (
        .value    (reg_wdata),
        .in_range (wdata_ok[g])
      );
    end
  endgenerate

  logic [5:0]  hit_slot;
  logic        hit;
  logic [4:0]  slot;
  logic        is_status;
  cfg_array_t  c;
  ctrl_regs_pkg::settings_t s;

  assign hit_slot = cfg_lookup(reg_addr);
  assign hit = hit_slot[5];
  assign slot = hit_slot[4:0];
  assign is_status = (reg_addr == ctrl_regs_pkg::ADDR_CTRL_STATUS) ||
                     (reg_addr == ctrl_regs_pkg::ADDR_ALARM_STATE);

  always_comb begin
    next_state = state;
    next_state.ack = 1'b0;
    c = state.cfg;
    if (reg_wr) begin
      next_state.ack = 1'b1;
      if (hit && wdata_ok[slot]) begin
        c[slot] = reg_wdata;
        next_state.answer = ctrl_regs_pkg::ANS_OK;
      end else if (hit) begin
        next_state.answer = ctrl_regs_pkg::ANS_BAD_VALUE;
      end else if (is_status) begin
        next_state.answer = ctrl_regs_pkg::ANS_READ_ONLY;
      end else begin
        next_state.answer = ctrl_regs_pkg::ANS_BAD_ADDR;
      end
    end else if (reg_rd) begin
      next_state.ack = 1'b1;
      next_state.answer = ctrl_regs_pkg::ANS_OK;
      if (hit) begin
        next_state.rdata = state.cfg[slot];
      end else if (reg_addr == ctrl_regs_pkg::ADDR_CTRL_STATUS) begin
        next_state.rdata = status_word(ctrl_state);
      end else if (reg_addr == ctrl_regs_pkg::ADDR_ALARM_STATE) begin
        next_state.rdata = alarm_word(alarm_state);
      end else begin
        next_state.rdata = 16'h0000;
        next_state.answer = ctrl_regs_pkg::ANS_BAD_ADDR;
      end
    end
    next_state.cfg = c;

    // decoded settings follow the stored words with no extra delay
    s = state.settings;
    s.bit_rate = ctrl_regs_pkg::SPEED_BPS[
      c[ctrl_regs_pkg::IDX_SPEED][2:0]];
    unique case (c[ctrl_regs_pkg::IDX_FRAMING][2:0])
      ctrl_regs_pkg::FRAME_8N2: begin
        s.link_enable = 1'b1;
        s.parity_enable = 1'b0;
        s.parity_odd = 1'b0;
        s.two_stop_bits = 1'b1;
      end
      ctrl_regs_pkg::FRAME_8E1: begin
        s.link_enable = 1'b1;
        s.parity_enable = 1'b1;
        s.parity_odd = 1'b0;
        s.two_stop_bits = 1'b0;
      end
      ctrl_regs_pkg::FRAME_8O1: begin
        s.link_enable = 1'b1;
        s.parity_enable = 1'b1;
        s.parity_odd = 1'b1;
        s.two_stop_bits = 1'b0;
      end
      ctrl_regs_pkg::FRAME_8N1: begin
        s.link_enable = 1'b1;
        s.parity_enable = 1'b0;
        s.parity_odd = 1'b0;
        s.two_stop_bits = 1'b0;
      end
      // code 0; other codes cannot be stored
      default: begin
        s.link_enable = 1'b0;
        s.parity_enable = 1'b0;
        s.parity_odd = 1'b0;
        s.two_stop_bits = 1'b0;
      end
    endcase
    s.retx_source = ctrl_regs_pkg::retx_source_t'(
      c[ctrl_regs_pkg::IDX_RETX_SRC][2:0]);
    s.retx_low = c[ctrl_regs_pkg::IDX_RETX_LOW];
    s.retx_high = c[ctrl_regs_pkg::IDX_RETX_HIGH];
    s.menu_code = c[ctrl_regs_pkg::IDX_MENU_CODE];
    s.tune_permit = c[ctrl_regs_pkg::IDX_TUNE_LOCK][0];
    s.tune_low = c[ctrl_regs_pkg::IDX_TUNE_LOW];
    s.tune_high = c[ctrl_regs_pkg::IDX_TUNE_HIGH];
    s.monitor_exit_delay =
      c[ctrl_regs_pkg::IDX_MON_EXIT][7:0];
    s.countdown_run = c[ctrl_regs_pkg::IDX_CD_ENABLE][0];
    s.countdown_tenth_min = c[ctrl_regs_pkg::IDX_CD_DURATION];
    s.aux_monitor_on = c[ctrl_regs_pkg::IDX_AUX_MON][0];
    s.heater_monitor_on = c[ctrl_regs_pkg::IDX_HEAT_MON][0];
    s.out3_period_tenth_s =
      c[ctrl_regs_pkg::IDX_OUT3_PERIOD][9:0];
    s.stepper_feedback = c[ctrl_regs_pkg::IDX_STEP_FB][0];
    s.short_setpoint = c[ctrl_regs_pkg::IDX_SHORT_SP][9:0];
    s.short_hysteresis = c[ctrl_regs_pkg::IDX_SHORT_HY][9:0];
    s.valve_open_tenth_s =
      c[ctrl_regs_pkg::IDX_VALVE_OPEN][12:0];
    s.valve_close_tenth_s =
      c[ctrl_regs_pkg::IDX_VALVE_CLOSE][12:0];
    s.valve_min_work_tenth_s =
      c[ctrl_regs_pkg::IDX_VALVE_MINWORK][9:0];
    s.ysig_min = c[ctrl_regs_pkg::IDX_YSIG_MIN][9:0];
    s.ysig_max = c[ctrl_regs_pkg::IDX_YSIG_MAX][9:0];
    next_state.settings = s;
  end

  // reset image: table values for storage, settings decoded from them
  function automatic state_t reset_image();
    state_t r;
    r = '0;
    for (int i = 0; i < ctrl_regs_pkg::NUM_CFG; i++) begin
      r.cfg[i] = ctrl_regs_pkg::CFG_RESET[i];
    end
    r.settings.bit_rate = ctrl_regs_pkg::SPEED_BPS[
      ctrl_regs_pkg::CFG_RESET[ctrl_regs_pkg::IDX_SPEED][2:0]];
    r.settings.link_enable = 1'b1;
    r.settings.two_stop_bits = 1'b1;
    r.settings.retx_high = ctrl_regs_pkg::CFG_RESET[
      ctrl_regs_pkg::IDX_RETX_HIGH];
    r.settings.tune_permit = 1'b1;
    r.settings.tune_high = ctrl_regs_pkg::CFG_RESET[
      ctrl_regs_pkg::IDX_TUNE_HIGH];
    r.settings.countdown_tenth_min = ctrl_regs_pkg::CFG_RESET[
      ctrl_regs_pkg::IDX_CD_DURATION];
    r.settings.out3_period_tenth_s = ctrl_regs_pkg::CFG_RESET[
      ctrl_regs_pkg::IDX_OUT3_PERIOD][9:0];
    r.settings.valve_open_tenth_s = ctrl_regs_pkg::CFG_RESET[
      ctrl_regs_pkg::IDX_VALVE_OPEN][12:0];
    r.settings.valve_close_tenth_s = ctrl_regs_pkg::CFG_RESET[
      ctrl_regs_pkg::IDX_VALVE_CLOSE][12:0];
    r.settings.valve_min_work_tenth_s = ctrl_regs_pkg::CFG_RESET[
      ctrl_regs_pkg::IDX_VALVE_MINWORK][9:0];
    r.settings.ysig_max = ctrl_regs_pkg::CFG_RESET[
      ctrl_regs_pkg::IDX_YSIG_MAX][9:0];
    return r;
  endfunction : reset_image

  localparam state_t STATE_RESET = reset_image();

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign reg_ack = state.ack;
  assign reg_answer = state.answer;
  assign settings = state.settings;

endmodule : controller_config_status_regs
`default_nettype wire

// file: testbench/ctrl_regs_monitor.sv
// assertions on the register bank's access and settings ports
// assumes one clock domain, rstn asynchronous active low
`timescale 1ns/10ps
`default_nettype none
module ctrl_regs_monitor (
  input wire logic                        mclk,
  input wire logic                        rstn,
  input wire logic [15:0]                 reg_addr,
  input wire logic                        reg_rd,
  input wire logic                        reg_wr,
  input wire logic [15:0]                 reg_wdata,
  input wire logic [15:0]                 reg_rdata,
  input wire logic                        reg_ack,
  input wire logic [1:0]                  reg_answer,
  input wire ctrl_regs_pkg::ctrl_state_t  ctrl_state,
  input wire ctrl_regs_pkg::alarm_state_t alarm_state,
  input wire ctrl_regs_pkg::settings_t    settings
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  function automatic logic [15:0] stat(ctrl_regs_pkg::ctrl_state_t s);
    return {s.controller_error, s.additional_out_of_range,
            s.main_out_of_range, 2'b00, s.pid_set, s.tune_active,
            s.manual_mode, s.timer_finished, s.soft_start_active,
            s.tune_failed, s.dp_additional, s.dp_main};
  endfunction : stat
  sequence s_wr(logic [15:0] a);
    reg_wr && reg_addr == a;
  endsequence
  sequence s_rd(logic [15:0] a);
    reg_rd && !reg_wr && reg_addr == a;
  endsequence
  a_speed_map: assert property (
    (s_wr(ctrl_regs_pkg::ADDR_SPEED) ##0 (reg_wdata <= 16'h0004)) |=>
    settings.bit_rate == ctrl_regs_pkg::SPEED_BPS[$past(reg_wdata[2:0])])
    else $error("bit rate not decoded from speed code");
  a_framing_off: assert property (
    (s_wr(ctrl_regs_pkg::ADDR_FRAMING) ##0 (reg_wdata == 16'h0000)) |=>
    !settings.link_enable) else $error("link still on after code 0");
  a_source_refuse: assert property (
    (s_wr(ctrl_regs_pkg::ADDR_RETX_SRC) ##0 (reg_wdata > 16'h0005)) |=>
    reg_answer == ctrl_regs_pkg::ANS_BAD_VALUE
    && $stable(settings.retx_source)) else $error("bad source kept");
  a_menu_store: assert property (
    (s_wr(ctrl_regs_pkg::ADDR_MENU_CODE) ##0 (reg_wdata <= 16'h270f)) |=>
    settings.menu_code == $past(reg_wdata)) else $error("menu code lost");
  a_exit_range: assert property (
    (s_wr(ctrl_regs_pkg::ADDR_MON_EXIT) ##0 (reg_wdata > 16'h00fa)) |=>
    reg_answer == ctrl_regs_pkg::ANS_BAD_VALUE) else $error("delay taken");
  a_valve_floor: assert property (
    (s_wr(ctrl_regs_pkg::ADDR_VALVE_OPEN) ##0 (reg_wdata < 16'h001e)) |=>
    reg_answer == ctrl_regs_pkg::ANS_BAD_VALUE
    && $stable(settings.valve_open_tenth_s)) else $error("short time kept");
  a_status_word: assert property (
    s_rd(ctrl_regs_pkg::ADDR_CTRL_STATUS) |=> reg_ack
    && reg_rdata == stat($past(ctrl_state))) else $error("status word");
  a_alarm_word: assert property (
    s_rd(ctrl_regs_pkg::ADDR_ALARM_STATE) |=> reg_rdata == {10'h000,
    $past(alarm_state.out1_short), $past(alarm_state.heater_burnout), 1'b0,
    $past(alarm_state.alarm_active)}) else $error("alarm word");
  a_status_ro: assert property (
    s_wr(ctrl_regs_pkg::ADDR_CTRL_STATUS) |=> reg_answer ==
    ctrl_regs_pkg::ANS_READ_ONLY && $stable(settings))
    else $error("status write not refused");
endmodule : ctrl_regs_monitor
bind controller_config_status_regs ctrl_regs_monitor ctrl_regs_monitor_inst (
  .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_ack(reg_ack), .reg_answer(reg_answer), .ctrl_state(ctrl_state),
  .alarm_state(alarm_state), .settings(settings));
`default_nettype wire

// file: testbench/reg_master.sv
// stand-in for the serial protocol engine: one register access at a time
// assumes the bank answers one cycle after the strobe edge
`timescale 1ns/10ps
`default_nettype none
module reg_master (
  input  wire logic        mclk,
  input  wire logic        reg_ack,
  output logic [15:0]      reg_addr,
  output logic             reg_rd,
  output logic             reg_wr,
  output logic [15:0]      reg_wdata
);
  initial begin
    reg_addr = 16'h0000;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
  end
  task automatic access(input logic wr, input logic [15:0] a,
                        input logic [15:0] d, output logic got);
    @(posedge mclk);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // released lines carry junk so stale values cannot pass for data
    reg_addr <= ~a;
    reg_wdata <= ~d;
    // the answer is taken at the edge after the one where its strobe is sampled high
    @(posedge mclk);
    got = reg_ack;
  endtask : access
endmodule : reg_master
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench of the register bank against an integer model
// assumes answers come one cycle after each strobe
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic                        mclk = 1'b0;
  logic                        rstn;
  logic [15:0]                 reg_addr, reg_wdata, reg_rdata;
  logic                        reg_rd, reg_wr, reg_ack;
  logic [1:0]                  reg_answer;
  ctrl_regs_pkg::ctrl_state_t  ctrl_state;
  ctrl_regs_pkg::alarm_state_t alarm_state;
  ctrl_regs_pkg::settings_t    settings;
  int                          error_cnt, compares;
  logic [31:0]                 seed;
  logic [15:0]                 model [23];
  int                          bps [5] = '{4800, 9600, 19200, 38400, 57600};
  logic [3:0]                  frm [5] = '{4'h0, 4'h9, 4'hc, 4'he, 4'h8};
  logic [15:0]                 holes [4] = '{16'h0ffe, 16'h100b,
                                             16'h1010, 16'h1019};
  controller_config_status_regs controller_config_status_regs_inst (
    .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .reg_answer(reg_answer), .ctrl_state(ctrl_state),
    .alarm_state(alarm_state), .settings(settings));
  reg_master reg_master_inst (.mclk(mclk), .reg_ack(reg_ack),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata));
  always #5 mclk = ~mclk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic wr, input logic [15:0] a, input logic
                     [15:0] d, input logic [1:0] ans, input logic [15:0] r);
    logic got;
    reg_master_inst.access(wr, a, d, got);
    chk({15'h0000, got}, 16'h0001);
    chk({14'h0000, reg_answer}, {14'h0000, ans});
    if (!wr) chk(reg_rdata, r);
  endtask : acc
  task automatic reset_and_read();
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 23; i++) begin
      model[i] = ctrl_regs_pkg::CFG_RESET[i];
      acc(1'b0, ctrl_regs_pkg::CFG_ADDR[i], 16'h0000, 2'h0, model[i]);
    end
  endtask : reset_and_read
  task automatic test_done();
    if (error_cnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end
  initial begin
    int i;
    logic [15:0] v, lo, hi;
    logic ok;
    ctrl_regs_pkg::ctrl_state_t cs;
    logic [4:0] as;
    rstn = 1'b0;
    seed = 32'h45bf70bb;
    ctrl_state = '0;
    alarm_state = '0;
    error_cnt = 0;
    compares = 0;
    reset_and_read();
    for (int n = 0; n < 300; n++) begin
      i = 32'(xs() % 23);
      lo = ctrl_regs_pkg::CFG_MIN[i];
      hi = ctrl_regs_pkg::CFG_MAX[i];
      case (xs() % 4)
        0: v = lo - 16'h0001;
        1: v = hi;
        2: v = hi + 16'h0001;
        default: v = 16'(xs());
      endcase
      ok = (v >= lo) && (v <= hi);
      if (ok) model[i] = v;
      acc(1'b1, ctrl_regs_pkg::CFG_ADDR[i], v, ok ? 2'h0 : 2'h2, 16'h0);
      acc(1'b0, ctrl_regs_pkg::CFG_ADDR[i], 16'h0, 2'h0, model[i]);
    end
    chk(settings.menu_code, model[ctrl_regs_pkg::IDX_MENU_CODE]);
    chk(16'(settings.tune_permit), model[ctrl_regs_pkg::IDX_TUNE_LOCK]);
    chk(16'(settings.out3_period_tenth_s), model[14]);
    chk(16'(settings.valve_open_tenth_s), model[18]);
    chk(16'(settings.ysig_max), model[22]);
    chk(16'(settings.retx_source), model[2]);
    chk(settings.retx_low, model[3]);
    chk(settings.retx_high, model[4]);
    chk(settings.tune_low, model[7]);
    chk(settings.tune_high, model[8]);
    chk(16'(settings.monitor_exit_delay), model[9]);
    chk(16'(settings.countdown_run), model[10]);
    chk(settings.countdown_tenth_min, model[11]);
    chk(16'(settings.aux_monitor_on), model[12]);
    chk(16'(settings.heater_monitor_on), model[13]);
    chk(16'(settings.stepper_feedback), model[15]);
    chk(16'(settings.short_setpoint), model[16]);
    chk(16'(settings.short_hysteresis), model[17]);
    chk(16'(settings.valve_close_tenth_s), model[19]);
    chk(16'(settings.valve_min_work_tenth_s), model[20]);
    chk(16'(settings.ysig_min), model[21]);
    for (int k = 0; k < 5; k++) begin
      acc(1'b1, ctrl_regs_pkg::ADDR_SPEED, 16'(k), 2'h0, 16'h0);
      chk(settings.bit_rate, 16'(bps[k]));
      acc(1'b1, ctrl_regs_pkg::ADDR_FRAMING, 16'(k), 2'h0, 16'h0);
      chk(16'({settings.link_enable, settings.parity_enable,
          settings.parity_odd, settings.two_stop_bits}), 16'(frm[k]));
    end
    foreach (holes[j]) begin
      acc(1'b0, holes[j], 16'h0, 2'h1, 16'h0);
      acc(1'b1, holes[j], 16'(xs()), 2'h1, 16'h0);
    end
    for (int n = 0; n < 20; n++) begin
      cs = 14'(xs());
      as = 5'(xs());
      @(posedge mclk);
      ctrl_state <= cs;
      alarm_state <= as;
      acc(1'b0, ctrl_regs_pkg::ADDR_CTRL_STATUS, 16'h0, 2'h0, {cs[0], cs[1],
          cs[2], 2'b00, cs[4:3], cs[5], cs[6], cs[7], cs[8], cs[9],
          cs[11:10], cs[13:12]});
      acc(1'b0, ctrl_regs_pkg::ADDR_ALARM_STATE, 16'h0, 2'h0,
          {10'h000, as[0], as[1], 1'b0, as[4:2]});
      acc(1'b1, ctrl_regs_pkg::ADDR_CTRL_STATUS, 16'(xs()), 2'h3, 16'h0);
      acc(1'b1, ctrl_regs_pkg::ADDR_ALARM_STATE, 16'(xs()), 2'h3, 16'h0);
    end
    reset_and_read();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
